/* File: pkg/brc_pkg.sv */
`default_nettype none
package brc_pkg;
    // ----------------------------------------
    // Core widths
    // ----------------------------------------
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam int FLAG_W = 8;
    localparam int OP_W = 4;
    localparam int CNT_W = 32;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // ----------------------------------------
    // Status flag positions
    // ----------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;

    // ----------------------------------------
    // Branch operations
    // ----------------------------------------
    typedef enum logic [3:0] {
        branch_on_carry_clear = 4'h0,
        branch_unsigned_same_or_higher = 4'h1,
        branch_unsigned_lower = 4'h2,
        branch_on_negative = 4'h3,
        branch_on_positive = 4'h4,
        branch_signed_greater_equal = 4'h5,
        branch_signed_less_than = 4'h6,
        branch_on_half_carry_set = 4'h7,
        branch_on_half_carry_clear = 4'h8,
        branch_on_transfer_bit_set = 4'h9
    } brc_op_t;

    // ----------------------------------------
    // Sequencer states, gray along the path
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FLUSH = 2'b01
    } brc_state_t;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] REG_TAKEN_CNT = 8'h08;
    localparam logic [APB_AW-1:0] REG_FALL_CNT = 8'h0C;
    localparam logic [APB_AW-1:0] REG_LAST_TGT = 8'h10;

    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TAKEN_BIT = 1;
    localparam int STAT_OP_LSB = 4;
    localparam int STAT_VALID_BIT = 8;
    localparam logic [APB_DW-1:0] ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: hdl/brc_cond_eval.sv */
`timescale 1ns/1ns
`default_nettype none
module brc_cond_eval (
    // Decoded operation
    input wire logic [brc_pkg::OP_W-1:0] op,
    // Status flags, read only
    input wire logic [brc_pkg::FLAG_W-1:0] flags,
    // Result
    output logic taken,
    output logic legal
);
    logic c_f;
    logic n_f;
    logic v_f;
    logic h_f;
    logic t_f;

    assign c_f = flags[brc_pkg::FLAG_C];
    assign n_f = flags[brc_pkg::FLAG_N];
    assign v_f = flags[brc_pkg::FLAG_V];
    assign h_f = flags[brc_pkg::FLAG_H];
    assign t_f = flags[brc_pkg::FLAG_T];

    // ----------------------------------------
    // Condition table
    // ----------------------------------------
    always_comb begin
        legal = 1'b1;
        case (brc_pkg::brc_op_t'(op))
            brc_pkg::branch_on_carry_clear: taken = ~c_f;
            brc_pkg::branch_unsigned_same_or_higher: taken = ~c_f;
            brc_pkg::branch_unsigned_lower: taken = c_f;
            brc_pkg::branch_on_negative: taken = n_f;
            brc_pkg::branch_on_positive: taken = ~n_f;
            brc_pkg::branch_signed_greater_equal: taken = ~(n_f ^ v_f);
            brc_pkg::branch_signed_less_than: taken = n_f ^ v_f;
            brc_pkg::branch_on_half_carry_set: taken = h_f;
            brc_pkg::branch_on_half_carry_clear: taken = ~h_f;
            brc_pkg::branch_on_transfer_bit_set: taken = t_f;
            default: begin
                // Unknown codes fall through as a sequential step
                taken = 1'b0;
                legal = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: hdl/brc_unit.sv */
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - carry clear jumps to pc plus k+1
// - same or higher jumps when carry zero
// - lower jumps when carry one
// - minus jumps when negative one
// - plus jumps when negative zero
// - signed ge jumps when N xor V zero
// - signed lt jumps when N xor V one
// - half carry set jumps when H one
// - half carry clear jumps when H zero
// - transfer set jumps when T one
// - every branch takes one or two cycles
// - branches never modify any status flag
module brc_unit #(
    parameter int PC_W = brc_pkg::PC_W,
    parameter int OFS_W = brc_pkg::OFS_W,
    parameter int CNT_W = brc_pkg::CNT_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [brc_pkg::APB_AW-1:0] paddr,
    input wire logic [brc_pkg::APB_DW-1:0] pwdata,
    output logic [brc_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder side
    input wire logic br_valid,
    input wire logic [brc_pkg::OP_W-1:0] br_op,
    input wire logic [OFS_W-1:0] br_offset,
    input wire logic [brc_pkg::FLAG_W-1:0] sreg_flags,
    output logic br_busy,
    output logic br_done,
    output logic br_taken,
    // Fetch and program counter side
    input wire logic [PC_W-1:0] pc_cur,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    output logic fetch_flush
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    brc_pkg::brc_state_t state_r;
    brc_pkg::brc_state_t state_nxt;
    logic ctrl_en_r;
    logic busy_r;
    logic done_r;
    logic taken_r;
    logic pc_load_r;
    logic flush_r;
    logic [PC_W-1:0] target_r;
    logic [PC_W-1:0] target_nxt;
    logic [PC_W-1:0] pc_one;
    logic [PC_W-1:0] ofs_ext;
    logic [CNT_W-1:0] taken_cnt_r;
    logic [CNT_W-1:0] fall_cnt_r;
    logic [brc_pkg::OP_W-1:0] last_op_r;
    logic last_taken_r;
    logic last_valid_r;
    logic cond_taken;
    logic cond_legal;
    logic accept;
    logic go_taken;
    logic go_fall;
    logic [brc_pkg::APB_DW-1:0] prdata_r;
    logic [brc_pkg::APB_DW-1:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic apb_setup;
    logic apb_wr;
    logic [brc_pkg::APB_DW-1:0] status_word;
    logic [CNT_W-1:0] cnt_one;
    logic wr_ctrl;
    logic wr_taken_clr;
    logic wr_fall_clr;

    // ----------------------------------------
    // Address decode helper
    // ----------------------------------------
    function automatic logic reg_hit(
        input logic [brc_pkg::APB_AW-1:0] addr
    );
        case (addr)
            brc_pkg::REG_CTRL,
            brc_pkg::REG_STATUS,
            brc_pkg::REG_TAKEN_CNT,
            brc_pkg::REG_FALL_CNT,
            brc_pkg::REG_LAST_TGT: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Condition evaluation
    // ----------------------------------------
    // flags only read
    brc_cond_eval u_cond (
        .op(br_op),
        .flags(sreg_flags),
        .taken(cond_taken),
        .legal(cond_legal)
    );

    // Requests during the flush cycle are ignored; decoder must hold off
    assign accept = br_valid & ctrl_en_r & (state_r == brc_pkg::ST_IDLE);
    assign go_taken = accept & cond_taken & cond_legal;
    assign go_fall = accept & ~go_taken;

    // ----------------------------------------
    // Target arithmetic
    // ----------------------------------------
    assign pc_one = {{(PC_W-1){1'b0}}, 1'b1};
    assign ofs_ext = {{(PC_W-OFS_W){br_offset[OFS_W-1]}}, br_offset};
    assign target_nxt = pc_cur + ofs_ext + pc_one;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            brc_pkg::ST_IDLE: begin
                if (go_taken) begin
                    state_nxt = brc_pkg::ST_FLUSH;
                end
            end
            brc_pkg::ST_FLUSH: begin
                state_nxt = brc_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = brc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= brc_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Program counter load and flush
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load_r <= 1'b0;
            flush_r <= 1'b0;
        end else begin
            pc_load_r <= go_taken;
            flush_r <= go_taken;
        end
    end

    // Target holds until the next taken branch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_r <= '0;
        end else if (go_taken) begin
            target_r <= target_nxt;
        end
    end

    // ----------------------------------------
    // Completion and busy
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= go_taken;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= go_fall | (state_r == brc_pkg::ST_FLUSH);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_r <= 1'b0;
        end else begin
            taken_r <= (state_r == brc_pkg::ST_FLUSH);
        end
    end

    // ----------------------------------------
    // Branch history
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_op_r <= '0;
            last_taken_r <= 1'b0;
            last_valid_r <= 1'b0;
        end else if (accept) begin
            last_op_r <= br_op;
            last_taken_r <= go_taken;
            last_valid_r <= cond_legal;
        end
    end

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    // No wait states; read data and response come from flip-flops loaded in the setup cycle
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready_r & pwrite & ~pslverr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= apb_setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (apb_setup) begin
            pslverr_r <= ~reg_hit(paddr);
        end else begin
            pslverr_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= brc_pkg::ZERO_WORD;
        end else if (apb_setup) begin
            prdata_r <= pwrite ? brc_pkg::ZERO_WORD : prdata_nxt;
        end
    end

    // ----------------------------------------
    // Register write strobes
    // ----------------------------------------
    assign wr_ctrl = apb_wr & (paddr == brc_pkg::REG_CTRL);
    assign wr_taken_clr = apb_wr & (paddr == brc_pkg::REG_TAKEN_CNT);
    assign wr_fall_clr = apb_wr & (paddr == brc_pkg::REG_FALL_CNT);

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= brc_pkg::CTRL_EN_RST;
        end else if (wr_ctrl) begin
            ctrl_en_r <= pwdata[brc_pkg::CTRL_EN_BIT];
        end
    end

    // ----------------------------------------
    // Outcome counters
    // ----------------------------------------
    assign cnt_one = {{(CNT_W-1){1'b0}}, 1'b1};

    // A count in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_cnt_r <= '0;
        end else if (go_taken) begin
            taken_cnt_r <= taken_cnt_r + cnt_one;
        end else if (wr_taken_clr) begin
            taken_cnt_r <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_cnt_r <= '0;
        end else if (go_fall) begin
            fall_cnt_r <= fall_cnt_r + cnt_one;
        end else if (wr_fall_clr) begin
            fall_cnt_r <= '0;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        status_word = brc_pkg::ZERO_WORD;
        status_word[brc_pkg::STAT_BUSY_BIT] = busy_r;
        status_word[brc_pkg::STAT_TAKEN_BIT] = last_taken_r;
        status_word[brc_pkg::STAT_OP_LSB +: brc_pkg::OP_W] = last_op_r;
        status_word[brc_pkg::STAT_VALID_BIT] = last_valid_r;
    end

    always_comb begin
        prdata_nxt = brc_pkg::ZERO_WORD;
        case (paddr)
            brc_pkg::REG_CTRL: begin
                prdata_nxt[brc_pkg::CTRL_EN_BIT] = ctrl_en_r;
            end
            brc_pkg::REG_STATUS: begin
                prdata_nxt = status_word;
            end
            brc_pkg::REG_TAKEN_CNT: begin
                prdata_nxt[CNT_W-1:0] = taken_cnt_r;
            end
            brc_pkg::REG_FALL_CNT: begin
                prdata_nxt[CNT_W-1:0] = fall_cnt_r;
            end
            brc_pkg::REG_LAST_TGT: begin
                prdata_nxt[PC_W-1:0] = target_r;
            end
            default: begin
                prdata_nxt = brc_pkg::ZERO_WORD;
            end
        endcase
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign br_busy = busy_r;
    assign br_done = done_r;
    assign br_taken = taken_r;
    assign pc_load = pc_load_r;
    assign pc_target = target_r;
    assign fetch_flush = flush_r;
endmodule
`default_nettype wire

/* File: bench/brc_unit_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module brc_unit_monitor #(
    parameter int PC_W = 16,
    parameter int OFS_W = 7,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Decoder side
    input wire logic br_valid,
    input wire logic [brc_pkg::OP_W-1:0] br_op,
    input wire logic [OFS_W-1:0] br_offset,
    input wire logic [brc_pkg::FLAG_W-1:0] sreg_flags,
    input wire logic br_busy,
    input wire logic br_done,
    input wire logic br_taken,
    // Fetch side
    input wire logic [PC_W-1:0] pc_cur,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic fetch_flush
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Taken branch steps
    // ----------------------------------------
    sequence s_redirect;
        pc_load && fetch_flush && br_busy;
    endsequence
    sequence s_retire;
        br_done && br_taken && !pc_load;
    endsequence
    a_taken_two_step: assert property (
        pc_load |-> s_redirect ##1 s_retire)
        else $error("taken branch did not retire in two cycles");
    a_taken_has_load: assert property (
        br_taken |-> br_done && $past(pc_load))
        else $error("taken retire without redirect");
    a_fall_one_cycle: assert property (
        br_done && !br_taken |-> $past(br_valid) && !$past(br_busy))
        else $error("not taken retire without request one cycle before");
    a_target_sum: assert property (
        pc_load |-> pc_target == $past(pc_cur) + PC_W'(1) +
        {{(PC_W-OFS_W){$past(br_offset[OFS_W-1])}}, $past(br_offset)})
        else $error("branch target is not pc plus offset plus one");
    a_target_holds: assert property (
        !pc_load |-> $stable(pc_target))
        else $error("target changed without a load");
    a_lower_carry: assert property (
        br_valid && !br_busy && br_op == brc_pkg::branch_unsigned_lower &&
        !sreg_flags[brc_pkg::FLAG_C] |=> !pc_load)
        else $error("lower branch jumped with carry clear");
    a_plus_neg: assert property (
        br_valid && !br_busy && br_op == brc_pkg::branch_on_positive &&
        sreg_flags[brc_pkg::FLAG_N] |=> !pc_load)
        else $error("plus branch jumped with negative set");
    a_ack_next: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not exactly one cycle after setup");
    a_err_with_ack: assert property (
        pslverr |-> pready)
        else $error("error flag without ready");
endmodule
`default_nettype wire

/* File: bench/brc_fetch_model.sv */
`timescale 1ns/1ns
`default_nettype none
module brc_fetch_model #(
    parameter int PC_W = 16,
    parameter logic [15:0] PC_RST = 16'h0100
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Redirect from the branch unit
    input wire logic pc_load,
    input wire logic fetch_flush,
    input wire logic [PC_W-1:0] pc_target,
    output logic [PC_W-1:0] pc_cur
);
    // Holds still between branches so targets stay predictable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_cur <= PC_RST;
        end else if (pc_load && fetch_flush) begin
            pc_cur <= pc_target;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, br_valid = 1'b0;
    logic [7:0] paddr = 8'h00, sreg_flags = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, br_busy, br_done, br_taken, pc_load;
    logic fetch_flush, er, g;
    logic [3:0] br_op = 4'h0;
    logic [6:0] br_offset = 7'h00;
    logic [15:0] pc_cur, pc_target, exp_pc;
    logic [7:0] pat [4] = '{8'h00, 8'h6D, 8'h04, 8'h08};
    logic [6:0] ofs [4] = '{7'h3F, 7'h40, 7'h00, 7'h7F};
    int err_total = 0, samples_checked = 0, cycles = 0, n_taken = 0;
    always #50 pclk = ~pclk;
    brc_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .br_valid, .br_op, .br_offset,
        .sreg_flags, .br_busy, .br_done, .br_taken, .pc_cur, .pc_load,
        .pc_target, .fetch_flush);
    brc_fetch_model partner (.pclk, .presetn, .pc_load, .fetch_flush,
        .pc_target, .pc_cur);
    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Slave answer waited for, never assumed
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic cond(input logic [3:0] op, input logic [7:0] f);
        case (op)
            4'h0, 4'h1: return !f[0];
            4'h2: return f[0];
            4'h3: return f[2];
            4'h4: return !f[2];
            4'h5: return !(f[2] ^ f[3]);
            4'h6: return f[2] ^ f[3];
            4'h7: return f[5];
            4'h8: return !f[5];
            4'h9: return f[6];
            default: return 1'b0;
        endcase
    endfunction
    task automatic branch(input logic [3:0] op, input logic [6:0] k,
            input logic [7:0] f, input logic go, input logic en);
        logic [15:0] tgt;
        tgt = exp_pc + 16'(signed'(k)) + 16'h0001;
        @(posedge pclk);
        br_valid <= 1'b1;
        br_op <= op;
        br_offset <= k;
        sreg_flags <= f;
        @(posedge pclk);
        br_valid <= 1'b0;
        @(negedge pclk);
        check("pc_load", pc_load, go);
        check("br_done", br_done, en && !go);
        if (go) begin
            check("pc_target", pc_target, tgt);
            check("fetch_flush", fetch_flush, 1'b1);
            @(negedge pclk);
            check("br_taken", br_taken, 1'b1);
            check("br_done", br_done, 1'b1);
            exp_pc = tgt;
        end
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 3000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        exp_pc = 16'h0100;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0000_0000);
        check("ctrl", rd, 32'h0000_0001);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check("taken_cnt", rd, 32'h0000_0000);
        $display("test reset done");
        // Every legal code plus one illegal code, over four flag patterns
        for (int o = 0; o < 11; o++) begin
            for (int p = 0; p < 4; p++) begin
                g = cond(4'(o), pat[p]);
                branch(4'(o), ofs[p], pat[p], g, 1'b1);
                n_taken += int'(g);
            end
        end
        apb(1'b0, 8'h04, 32'h0000_0000);
        check("status", rd, 32'h0000_00A0);
        $display("test conditions done");
        apb(1'b0, 8'h08, 32'h0000_0000);
        check("taken_cnt", rd, 32'(n_taken));
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check("fall_cnt", rd, 32'(44 - n_taken));
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("last_tgt", rd, {16'h0000, exp_pc});
        apb(1'b1, 8'h08, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check("taken_cnt", rd, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check("pslverr", er, 1'b1);
        check("prdata", rd, 32'h0000_0000);
        $display("test registers done");
        // Disabled unit ignores a request that would jump
        apb(1'b1, 8'h00, 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check("ctrl", rd, 32'h0000_0000);
        branch(4'h2, 7'h01, 8'h01, 1'b0, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        branch(4'h2, 7'h01, 8'h01, 1'b1, 1'b1);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check("status", rd, 32'h0000_0122);
        $display("test enable done");
        // A request held into the flush cycle must be ignored
        apb(1'b1, 8'h08, 32'h0000_0000);
        @(posedge pclk);
        br_valid <= 1'b1;
        repeat (2) @(posedge pclk);
        br_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check("taken_cnt", rd, 32'h0000_0001);
        $display("test flush done");
        end_of_test();
    end
endmodule
bind brc_unit brc_unit_monitor #(.PC_W(PC_W), .OFS_W(OFS_W),
    .CNT_W(CNT_W)) u_mon (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .br_valid, .br_op, .br_offset, .sreg_flags, .br_busy,
    .br_done, .br_taken, .pc_cur, .pc_load, .pc_target, .fetch_flush);
`default_nettype wire
